/* File: src/iemg_defines.svh */
// constants for the interrupt enable and operating mode guard block
// Functional notes
// - receive-all still reports filter match result
// - enable bit one enables its status flag
// - any reset clears every interrupt enable
// - normal summary gates status bits 0, 2, 6, 10
// - abnormal summary gates the abnormal status bits
// - bus error needs enable, summary and flag
// - timer expiry needs enable, summary and flag
// - early transmit needs enable, normal summary, flag
// - receive watchdog needs enable, abnormal summary, flag
// - remaining enables pair with their group summary
`ifndef IEMG_DEFINES_SVH
`define IEMG_DEFINES_SVH

`define IEMG_OFF_BUS_MODE   8'h00
`define IEMG_OFF_RX_LIST    8'h18
`define IEMG_OFF_TX_LIST    8'h20
`define IEMG_OFF_STATUS     8'h28
`define IEMG_OFF_MODE       8'h30
`define IEMG_OFF_MASK       8'h38
`define IEMG_OFF_STAT_CLR   8'h3C

`define IEMG_LOW_ADDR_MASK  8'hFF
`define IEMG_SRST_BIT       0

`define IEMG_MODE_RESET     32'h3200_0040
`define IEMG_MODE_RO        32'h0000_0001
`define IEMG_MODE_TX_ONLY   32'h0000_C100
`define IEMG_MODE_RX_ONLY   32'h0000_0008
`define IEMG_MODE_BOTH      32'h0063_1220
`define IEMG_MODE_LOOP      32'h0000_0C00
`define IEMG_MODE_CMD       32'h0000_2002
`define IEMG_TX_START_BIT   13
`define IEMG_RX_START_BIT   1
`define IEMG_RX_ALL_BIT     30
`define IEMG_LOOP_HI_BIT    11
`define IEMG_LOOP_LO_BIT    10
`define IEMG_LOOP_INTERNAL  2'h1

`define IEMG_MASK_RO_ONES   32'hFFFE_0000
`define IEMG_MASK_RW        17'h1_AFEF
`define IEMG_NORMAL_BITS    32'h0000_0445
`define IEMG_ABNORMAL_BITS  32'h0000_2BAA
`define IEMG_EVT_BITS       14'h2FEF
`define IEMG_NIS_BIT        16
`define IEMG_AIS_BIT        15
`define IEMG_TS_BIT         1
`define IEMG_RS_BIT         8
`define IEMG_BUS_ERR_BIT    13
`define IEMG_TIMER_BIT      11
`define IEMG_EARLY_TX_BIT   10
`define IEMG_RX_WDOG_BIT    9
`define IEMG_RX_UNAVAIL_BIT 7

`endif

/* File: src/iemg_pkg.sv */
// types shared by the interrupt enable and mode guard block
package iemg_pkg;

	typedef enum logic [1:0] {
		IEMG_STOPPED   = 2'h0,
		IEMG_RUNNING   = 2'h1,
		IEMG_SUSPENDED = 2'h2
	} iemg_proc_t;

	typedef struct packed {
		logic [7:0]  addr;
		logic [31:0] wdata;
		logic        write;
	} iemg_apb_req_t;

	typedef struct packed {
		logic tx_stopped;
		logic rx_stopped;
		logic tx_init;
		logic rx_init;
	} iemg_guard_ctx_t;

endpackage

/* File: src/iemg_apb_slave.sv */
// apb slave front end with one wait state and error on unmapped access
`timescale 1ns/100ps
`include "iemg_defines.svh"
module iemg_apb_slave #(
	parameter int ADDR_W = 8
) (
	input  wire logic                  pclk,
	input  wire logic                  presetn,
	input  wire logic                  psel,
	input  wire logic                  penable,
	input  wire logic                  pwrite,
	input  wire logic [ADDR_W-1:0]     paddr,
	input  wire logic [31:0]           pwdata,
	input  wire logic [31:0]           rd_data,
	input  wire logic                  addr_hit,
	output wire logic                  hi_zero,
	output iemg_pkg::iemg_apb_req_t    req,
	output wire logic                  wr_stb,
	output logic                       pready,
	output logic [31:0]                prdata,
	output logic                       pslverr
);
	wire logic [ADDR_W-1:0] low_mask = ADDR_W'(`IEMG_LOW_ADDR_MASK);
	wire logic              access   = psel & penable;

	generate
		if (ADDR_W < 8) begin : g_bad_width
			$error("iemg_apb_slave: ADDR_W must be at least 8");
		end
	endgenerate

	assign hi_zero = (paddr & ~low_mask) == '0;
	assign req     = '{addr: paddr[7:0], wdata: pwdata, write: pwrite};
	// a write lands only on the completing edge, never on an error
	assign wr_stb  = access & pready & pwrite & ~pslverr;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			prdata  <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else if (access && !pready) begin
			pready  <= 1'b1;
			prdata  <= (addr_hit && !pwrite) ? rd_data : 32'h0000_0000;
			pslverr <= ~addr_hit;
		end else begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end
	end
endmodule

/* File: src/iemg_mode_guard.sv */
// write permission filter for the operating mode register
`timescale 1ns/100ps
`include "iemg_defines.svh"
module iemg_mode_guard (
	input  wire logic [31:0]            cur_mode,
	input  wire logic [31:0]            wdata,
	input  iemg_pkg::iemg_guard_ctx_t   ctx,
	output wire logic [31:0]            next_mode
);
	wire logic        both_stopped = ctx.tx_stopped & ctx.rx_stopped;
	wire logic        int_loop     = cur_mode[`IEMG_LOOP_HI_BIT:`IEMG_LOOP_LO_BIT]
		== `IEMG_LOOP_INTERNAL;
	wire logic [31:0] free_bits    = ~(`IEMG_MODE_RO | `IEMG_MODE_TX_ONLY | `IEMG_MODE_RX_ONLY
		| `IEMG_MODE_BOTH | `IEMG_MODE_LOOP | `IEMG_MODE_CMD);
	wire logic [31:0] allow = free_bits
		| (ctx.tx_stopped ? `IEMG_MODE_TX_ONLY : 32'h0000_0000)
		| (ctx.rx_stopped ? `IEMG_MODE_RX_ONLY : 32'h0000_0000)
		| (both_stopped ? `IEMG_MODE_BOTH : 32'h0000_0000)
		| ((both_stopped | int_loop) ? `IEMG_MODE_LOOP : 32'h0000_0000);
	wire logic [31:0] merged = (cur_mode & ~allow) | (wdata & allow);
	// a start without an initialised list base is dropped rather than run wild
	wire logic tx_cmd = wdata[`IEMG_TX_START_BIT]
		& (cur_mode[`IEMG_TX_START_BIT] | ctx.tx_init);
	wire logic rx_cmd = wdata[`IEMG_RX_START_BIT]
		& (cur_mode[`IEMG_RX_START_BIT] | ctx.rx_init);

	assign next_mode = (merged & ~`IEMG_MODE_CMD)
		| ({31'h0000_0000, tx_cmd} << `IEMG_TX_START_BIT)
		| ({31'h0000_0000, rx_cmd} << `IEMG_RX_START_BIT);
endmodule

/* File: src/iemg_top.sv */
// interrupt enable masking, status flags and operating mode write guard
`timescale 1ns/100ps
`include "iemg_defines.svh"
module iemg_top #(
	parameter int ADDR_W = 8
) (
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic [31:0]       pwdata,
	output wire logic [31:0]       prdata,
	output wire logic              pready,
	output wire logic              pslverr,
	input  wire logic [13:0]       status_event,
	input  wire logic              tx_suspend,
	input  wire logic              tx_resume,
	input  wire logic              rx_suspend,
	input  wire logic              rx_resume,
	input  wire logic              rx_frame_done,
	input  wire logic              rx_filter_match,
	output logic                   irq,
	output logic [31:0]            operating_mode,
	output iemg_pkg::iemg_proc_t   tx_state,
	output iemg_pkg::iemg_proc_t   rx_state,
	output logic [31:0]            tx_list_base,
	output logic [31:0]            rx_list_base,
	output logic                   rx_desc_match,
	output logic                   rx_frame_accept
);
	generate
		if (ADDR_W < 8) begin : g_bad_width
			$error("iemg_top: ADDR_W must be at least 8");
		end
	endgenerate

	function automatic iemg_pkg::iemg_proc_t proc_next(
		input iemg_pkg::iemg_proc_t st,
		input logic                 run,
		input logic                 susp,
		input logic                 res
	);
		case (st)
			iemg_pkg::IEMG_STOPPED: begin
				proc_next = run ? iemg_pkg::IEMG_RUNNING : iemg_pkg::IEMG_STOPPED;
			end
			iemg_pkg::IEMG_RUNNING: begin
				if (!run)
					proc_next = iemg_pkg::IEMG_STOPPED;
				else
					proc_next = susp ? iemg_pkg::IEMG_SUSPENDED : iemg_pkg::IEMG_RUNNING;
			end
			iemg_pkg::IEMG_SUSPENDED: begin
				if (!run)
					proc_next = iemg_pkg::IEMG_STOPPED;
				else
					proc_next = res ? iemg_pkg::IEMG_RUNNING : iemg_pkg::IEMG_SUSPENDED;
			end
			default: begin
				proc_next = iemg_pkg::IEMG_STOPPED;
			end
		endcase
	endfunction

	iemg_pkg::iemg_apb_req_t   req;
	iemg_pkg::iemg_guard_ctx_t ctx;
	logic                      hi_zero;
	logic                      wr_stb;
	logic [31:0]               next_mode;
	logic [31:0]               rd_data;
	logic                      srst;
	logic                      tx_init;
	logic                      rx_init;
	logic [13:0]               status;
	logic [16:0]               mask;

	// register decode
	wire logic sel_bus  = req.addr == `IEMG_OFF_BUS_MODE;
	wire logic sel_rxl  = req.addr == `IEMG_OFF_RX_LIST;
	wire logic sel_txl  = req.addr == `IEMG_OFF_TX_LIST;
	wire logic sel_stat = req.addr == `IEMG_OFF_STATUS;
	wire logic sel_mode = req.addr == `IEMG_OFF_MODE;
	wire logic sel_mask = req.addr == `IEMG_OFF_MASK;
	wire logic sel_clr  = req.addr == `IEMG_OFF_STAT_CLR;
	wire logic addr_hit = hi_zero
		& (sel_bus | sel_rxl | sel_txl | sel_stat | sel_mode | sel_mask | sel_clr);

	wire logic bus_wr  = wr_stb & sel_bus;
	wire logic rxl_wr  = wr_stb & sel_rxl;
	wire logic txl_wr  = wr_stb & sel_txl;
	wire logic mode_wr = wr_stb & sel_mode;
	wire logic mask_wr = wr_stb & sel_mask;
	wire logic clr_wr  = wr_stb & sel_clr;

	// process state and stop events
	wire iemg_pkg::iemg_proc_t next_tx = proc_next(tx_state,
		operating_mode[`IEMG_TX_START_BIT], tx_suspend, tx_resume);
	wire iemg_pkg::iemg_proc_t next_rx = proc_next(rx_state,
		operating_mode[`IEMG_RX_START_BIT], rx_suspend, rx_resume);
	wire logic tx_stop_evt = (tx_state != iemg_pkg::IEMG_STOPPED)
		& (next_tx == iemg_pkg::IEMG_STOPPED);
	wire logic rx_stop_evt = (rx_state != iemg_pkg::IEMG_STOPPED)
		& (next_rx == iemg_pkg::IEMG_STOPPED);

	// sticky status flags; set beats clear in the same cycle
	wire logic [13:0] evt_bits = (status_event & `IEMG_EVT_BITS)
		| ({13'h0000, tx_stop_evt} << `IEMG_TS_BIT)
		| ({13'h0000, rx_stop_evt} << `IEMG_RS_BIT);
	wire logic [13:0] clr_bits    = clr_wr ? req.wdata[13:0] : 14'h0000;
	wire logic [13:0] next_status = (status & ~clr_bits) | evt_bits;

	wire logic [31:0] flags    = {18'h0_0000, status};
	wire logic        norm_sum = |(flags & `IEMG_NORMAL_BITS);
	wire logic        abn_sum  = |(flags & `IEMG_ABNORMAL_BITS);
	wire logic [31:0] status_word = flags
		| ({31'h0000_0000, norm_sum} << `IEMG_NIS_BIT)
		| ({31'h0000_0000, abn_sum} << `IEMG_AIS_BIT);

	// per-flag enable paired with its group summary enable
	wire logic [31:0] mask_word = {15'h0000, mask};
	wire logic [31:0] group_en =
		(mask[`IEMG_NIS_BIT] ? `IEMG_NORMAL_BITS : 32'h0000_0000)
		| (mask[`IEMG_AIS_BIT] ? `IEMG_ABNORMAL_BITS : 32'h0000_0000);
	wire logic [31:0] mask_eff = mask_word & group_en;
	wire logic        irq_hit  = |(flags & mask_eff);
	wire logic        norm_hit = |(flags & mask_word & `IEMG_NORMAL_BITS);
	wire logic        abn_hit  = |(flags & mask_word & `IEMG_ABNORMAL_BITS);

	assign ctx = '{
		tx_stopped: tx_state == iemg_pkg::IEMG_STOPPED,
		rx_stopped: rx_state == iemg_pkg::IEMG_STOPPED,
		tx_init:    tx_init,
		rx_init:    rx_init
	};

	assign rd_data = sel_rxl  ? rx_list_base :
	                 sel_txl  ? tx_list_base :
	                 sel_stat ? status_word :
	                 sel_mode ? operating_mode :
	                 sel_mask ? (`IEMG_MASK_RO_ONES | mask_word) :
	                 32'h0000_0000;

	iemg_apb_slave #(
		.ADDR_W (ADDR_W)
	) u_apb (
		.pclk     (pclk),
		.presetn  (presetn),
		.psel     (psel),
		.penable  (penable),
		.pwrite   (pwrite),
		.paddr    (paddr),
		.pwdata   (pwdata),
		.rd_data  (rd_data),
		.addr_hit (addr_hit),
		.hi_zero  (hi_zero),
		.req      (req),
		.wr_stb   (wr_stb),
		.pready   (pready),
		.prdata   (prdata),
		.pslverr  (pslverr)
	);

	iemg_mode_guard u_guard (
		.cur_mode  (operating_mode),
		.wdata     (req.wdata),
		.ctx       (ctx),
		.next_mode (next_mode)
	);

	// software reset is a one-cycle pulse, bus mode reads back zero
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			srst <= 1'b0;
		else
			srst <= bus_wr & req.wdata[`IEMG_SRST_BIT];
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			operating_mode <= `IEMG_MODE_RESET;
			tx_state       <= iemg_pkg::IEMG_STOPPED;
			rx_state       <= iemg_pkg::IEMG_STOPPED;
		end else if (srst) begin
			operating_mode <= `IEMG_MODE_RESET;
			tx_state       <= iemg_pkg::IEMG_STOPPED;
			rx_state       <= iemg_pkg::IEMG_STOPPED;
		end else begin
			if (mode_wr)
				operating_mode <= next_mode;
			tx_state <= next_tx;
			rx_state <= next_rx;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_list_base <= 32'h0000_0000;
			rx_list_base <= 32'h0000_0000;
			tx_init      <= 1'b0;
			rx_init      <= 1'b0;
		end else if (srst) begin
			tx_init <= 1'b0;
			rx_init <= 1'b0;
		end else begin
			if (txl_wr) begin
				tx_list_base <= req.wdata;
				tx_init      <= 1'b1;
			end
			if (rxl_wr) begin
				rx_list_base <= req.wdata;
				rx_init      <= 1'b1;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			status <= 14'h0000;
			mask   <= 17'h0_0000;
			irq    <= 1'b0;
		end else if (srst) begin
			status <= 14'h0000;
			mask   <= 17'h0_0000;
			irq    <= 1'b0;
		end else begin
			status <= next_status;
			if (mask_wr)
				mask <= req.wdata[16:0] & `IEMG_MASK_RW;
			irq <= irq_hit;
		end
	end

	// filter verdict is kept even when receive-all passes every frame
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_desc_match   <= 1'b0;
			rx_frame_accept <= 1'b0;
		end else if (rx_frame_done) begin
			rx_desc_match   <= rx_filter_match;
			rx_frame_accept <= rx_filter_match | operating_mode[`IEMG_RX_ALL_BIT];
		end
	end

	sequence s_tx_start_ok;
		mode_wr && req.wdata[`IEMG_TX_START_BIT] && tx_init
			&& (tx_state == iemg_pkg::IEMG_STOPPED);
	endsequence

	sequence s_tx_runs;
		operating_mode[`IEMG_TX_START_BIT] ##1 (tx_state == iemg_pkg::IEMG_RUNNING);
	endsequence

	sequence s_rx_start_bad;
		mode_wr && req.wdata[`IEMG_RX_START_BIT] && !rx_init
			&& !operating_mode[`IEMG_RX_START_BIT];
	endsequence

	a_irq_follows_hit: assert property (
		@(posedge pclk) disable iff (!presetn)
		(!srst && (flags & mask_eff) != 32'h0000_0000) |=> irq
	) else $error("irq missing for enabled flag");

	a_irq_drops: assert property (
		@(posedge pclk) disable iff (!presetn)
		!irq_hit |=> !irq
	) else $error("irq stays without enabled flag");

	a_normal_gate: assert property (
		@(posedge pclk) disable iff (!presetn)
		(!mask[`IEMG_NIS_BIT] && !(mask[`IEMG_AIS_BIT] && abn_hit)) |=> !irq
	) else $error("normal flag raised irq without summary enable");

	a_abnormal_gate: assert property (
		@(posedge pclk) disable iff (!presetn)
		(!mask[`IEMG_AIS_BIT] && !(mask[`IEMG_NIS_BIT] && norm_hit)) |=> !irq
	) else $error("abnormal flag raised irq without summary enable");

	a_bus_err_irq: assert property (
		@(posedge pclk) disable iff (!presetn)
		(!srst && status[`IEMG_BUS_ERR_BIT] && mask[`IEMG_BUS_ERR_BIT]
			&& mask[`IEMG_AIS_BIT]) |=> irq
	) else $error("bus error did not raise irq");

	a_timer_masked: assert property (
		@(posedge pclk) disable iff (!presetn)
		(status == 14'h0800 && !mask[`IEMG_TIMER_BIT]) |=> !irq
	) else $error("timer expiry raised irq while disabled");

	a_early_tx_irq: assert property (
		@(posedge pclk) disable iff (!presetn)
		(!srst && status[`IEMG_EARLY_TX_BIT] && mask[`IEMG_EARLY_TX_BIT]
			&& mask[`IEMG_NIS_BIT]) |=> irq
	) else $error("early transmit did not raise irq");

	a_rx_wdog_irq: assert property (
		@(posedge pclk) disable iff (!presetn)
		(!srst && status[`IEMG_RX_WDOG_BIT] && mask[`IEMG_RX_WDOG_BIT]
			&& mask[`IEMG_AIS_BIT]) |=> irq
	) else $error("receive watchdog did not raise irq");

	a_pair_rx_unavail: assert property (
		@(posedge pclk) disable iff (!presetn)
		(status == 14'h0080 && mask[`IEMG_RX_UNAVAIL_BIT] && !mask[`IEMG_AIS_BIT]) |=> !irq
	) else $error("receive buffer flag ignored its group summary");

	a_mask_write: assert property (
		@(posedge pclk) disable iff (!presetn)
		(mask_wr && !srst) |=> mask == ($past(req.wdata[16:0]) & `IEMG_MASK_RW)
	) else $error("interrupt enable write not stored");

	a_soft_reset: assert property (
		@(posedge pclk) disable iff (!presetn)
		srst |=> (mask == 17'h0_0000) ##1 !irq
	) else $error("software reset left enables set");

	a_set_wins: assert property (
		@(posedge pclk) disable iff (!presetn)
		(!srst && clr_wr && status_event[`IEMG_BUS_ERR_BIT]) |=> status[`IEMG_BUS_ERR_BIT]
	) else $error("event lost against a clear");

	a_rx_match: assert property (
		@(posedge pclk) disable iff (!presetn)
		rx_frame_done |=> rx_desc_match == $past(rx_filter_match)
	) else $error("filter match not reported");

	a_tx_fields_held: assert property (
		@(posedge pclk) disable iff (!presetn)
		(mode_wr && !srst && tx_state != iemg_pkg::IEMG_STOPPED)
			|=> operating_mode[15:14] == $past(operating_mode[15:14])
	) else $error("threshold changed while transmit active");

	a_shared_held: assert property (
		@(posedge pclk) disable iff (!presetn)
		(mode_wr && !srst && rx_state != iemg_pkg::IEMG_STOPPED)
			|=> (operating_mode & `IEMG_MODE_BOTH) == ($past(operating_mode) & `IEMG_MODE_BOTH)
	) else $error("shared mode field changed while receive active");

	a_tx_start: assert property (
		@(posedge pclk) disable iff (!presetn)
		(s_tx_start_ok and !srst) |=> s_tx_runs
	) else $error("valid transmit start did not run");

	a_rx_start_blocked: assert property (
		@(posedge pclk) disable iff (!presetn)
		s_rx_start_bad |=> !operating_mode[`IEMG_RX_START_BIT]
	) else $error("receive started without list base");
endmodule

/* File: verification/iemg_tb.sv */
// self-checking bench for the interrupt enable and mode guard block
`timescale 1ns/100ps
`include "iemg_defines.svh"
module tb;
	logic                 pclk            = 1'h0;
	logic                 presetn         = 1'h0;
	logic                 psel            = 1'h0;
	logic                 penable         = 1'h0;
	logic                 pwrite          = 1'h0;
	logic [7:0]           paddr           = 8'h00;
	logic [31:0]          pwdata          = 32'h0000_0000;
	logic [13:0]          status_event    = 14'h0000;
	logic                 tx_suspend      = 1'h0;
	logic                 tx_resume       = 1'h0;
	logic                 rx_suspend      = 1'h0;
	logic                 rx_resume       = 1'h0;
	logic                 rx_frame_done   = 1'h0;
	logic                 rx_filter_match = 1'h0;
	logic [31:0]          prdata;
	logic                 pready;
	logic                 pslverr;
	logic                 irq;
	logic [31:0]          operating_mode;
	iemg_pkg::iemg_proc_t tx_state;
	iemg_pkg::iemg_proc_t rx_state;
	logic [31:0]          tx_list_base;
	logic [31:0]          rx_list_base;
	logic                 rx_desc_match;
	logic                 rx_frame_accept;
	logic [31:0]          rd;
	logic                 er;
	int                   fail_count = 0;
	int                   n_checks   = 0;
	int                   cyc        = 0;

	always #25 pclk = ~pclk;

	iemg_top u_dut (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.status_event(status_event), .tx_suspend(tx_suspend), .tx_resume(tx_resume),
		.rx_suspend(rx_suspend), .rx_resume(rx_resume), .rx_frame_done(rx_frame_done),
		.rx_filter_match(rx_filter_match), .irq(irq), .operating_mode(operating_mode),
		.tx_state(tx_state), .rx_state(rx_state), .tx_list_base(tx_list_base),
		.rx_list_base(rx_list_base), .rx_desc_match(rx_desc_match),
		.rx_frame_accept(rx_frame_accept)
	);

	task automatic results;
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		n_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
		end
	endtask

	task automatic idle(input int n);
		repeat (n) @(posedge pclk);
	endtask

	// one apb transfer; request held until pready is sampled high
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel   <= 1'h1;
		pwrite <= w;
		paddr  <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'h1);
		rd = prdata;
		er = pslverr;
		psel    <= 1'h0;
		penable <= 1'h0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'h1, a, d);
	endtask

	task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input string what);
		apb(1'h0, a, 32'h0);
		chk(rd, exp, what);
	endtask

	// irq lags status and mask by one cycle; three is margin
	task automatic irq_is(input logic e, input string what);
		idle(3);
		chk({31'h0, irq}, {31'h0, e}, what);
	endtask

	task automatic pulse(input int b);
		@(posedge pclk);
		status_event <= 14'h0001 << b;
		@(posedge pclk);
		status_event <= 14'h0000;
	endtask

	task automatic t_reset;
		chk({31'h0, irq}, 32'h0, "irq after reset");
		rdc(`IEMG_OFF_MASK, 32'hFFFE_0000, "mask reset");
		rdc(`IEMG_OFF_MODE, 32'h3200_0040, "mode reset");
		wr(`IEMG_OFF_MASK, 32'hFFFF_FFFF);
		rdc(`IEMG_OFF_MASK, 32'hFFFF_AFEF, "mask writable bits");
		apb(1'h0, 8'h44, 32'h0);
		chk({31'h0, er}, 32'h1, "unmapped error");
		chk(rd, 32'h0, "unmapped data");
	endtask

	// every flag against its own enable, its group and the wrong group
	task automatic t_gate;
		int bl[12] = '{0, 1, 2, 3, 5, 6, 7, 8, 9, 10, 11, 13};
		int b;
		int g;
		for (int i = 0; i < 12; i++) begin
			b = bl[i];
			g = (b == 0 || b == 2 || b == 6 || b == 10) ? 16 : 15;
			wr(`IEMG_OFF_MASK, 32'h0);
			wr(`IEMG_OFF_STAT_CLR, 32'hFFFF_FFFF);
			pulse(b);
			rdc(`IEMG_OFF_STATUS, (32'h1 << b) | (32'h1 << g), "status flag");
			wr(`IEMG_OFF_MASK, 32'h1 << b);
			irq_is(1'h0, "no group enable");
			wr(`IEMG_OFF_MASK, 32'h1 << g);
			irq_is(1'h0, "no own enable");
			wr(`IEMG_OFF_MASK, (32'h1 << b) | (32'h1 << (31 - g)));
			irq_is(1'h0, "wrong group");
			wr(`IEMG_OFF_MASK, (32'h1 << b) | (32'h1 << g));
			irq_is(1'h1, "enabled flag");
			wr(`IEMG_OFF_STAT_CLR, 32'h1 << b);
			irq_is(1'h0, "flag cleared");
		end
		wr(`IEMG_OFF_MASK, 32'h0);
	endtask

	task automatic t_mode;
		wr(`IEMG_OFF_MODE, 32'h3200_2040);
		rdc(`IEMG_OFF_MODE, 32'h3200_0040, "tx start before base");
		wr(`IEMG_OFF_TX_LIST, 32'h0000_1000);
		rdc(`IEMG_OFF_TX_LIST, 32'h0000_1000, "tx base readback");
		chk(tx_list_base, 32'h0000_1000, "tx base port");
		wr(`IEMG_OFF_MODE, 32'h3200_2040);
		rdc(`IEMG_OFF_MODE, 32'h3200_2040, "tx start");
		idle(2);
		chk({30'h0, tx_state}, {30'h0, iemg_pkg::IEMG_RUNNING}, "tx running");
		@(posedge pclk);
		tx_suspend <= 1'h1;
		@(posedge pclk);
		tx_suspend <= 1'h0;
		idle(2);
		chk({30'h0, tx_state}, {30'h0, iemg_pkg::IEMG_SUSPENDED}, "tx suspended");
		@(posedge pclk);
		tx_resume <= 1'h1;
		@(posedge pclk);
		tx_resume <= 1'h0;
		wr(`IEMG_OFF_MODE, 32'h3240_E148);
		rdc(`IEMG_OFF_MODE, 32'h3200_2048, "fields while tx runs");
		wr(`IEMG_OFF_MODE, 32'h3200_0048);
		idle(2);
		chk({30'h0, tx_state}, {30'h0, iemg_pkg::IEMG_STOPPED}, "tx stopped");
		rdc(`IEMG_OFF_STATUS, 32'h0000_8002, "tx stop flag");
		wr(`IEMG_OFF_MODE, 32'h3200_C048);
		rdc(`IEMG_OFF_MODE, 32'h3200_C048, "threshold while stopped");
		wr(`IEMG_OFF_MODE, 32'h3200_C04A);
		rdc(`IEMG_OFF_MODE, 32'h3200_C048, "rx start before base");
		wr(`IEMG_OFF_RX_LIST, 32'h0000_2000);
		rdc(`IEMG_OFF_RX_LIST, 32'h0000_2000, "rx base readback");
		chk(rx_list_base, 32'h0000_2000, "rx base port");
		wr(`IEMG_OFF_MODE, 32'h3200_C448);
		rdc(`IEMG_OFF_MODE, 32'h3200_C448, "internal loopback");
		wr(`IEMG_OFF_MODE, 32'h3200_C44A);
		rdc(`IEMG_OFF_MODE, 32'h3200_C44A, "rx start");
		idle(2);
		chk({30'h0, rx_state}, {30'h0, iemg_pkg::IEMG_RUNNING}, "rx running");
		// guarded fields stay locked while suspended, except that internal loopback can be left; stop is taken from suspended
		@(posedge pclk);
		rx_suspend <= 1'h1;
		@(posedge pclk);
		rx_suspend <= 1'h0;
		idle(2);
		chk({30'h0, rx_state}, {30'h0, iemg_pkg::IEMG_SUSPENDED}, "rx suspended");
		wr(`IEMG_OFF_MODE, 32'h3200_C442);
		rdc(`IEMG_OFF_MODE, 32'h3200_C44A, "bit3 while rx runs");
		wr(`IEMG_OFF_MODE, 32'h3200_C04A);
		rdc(`IEMG_OFF_MODE, 32'h3200_C04A, "leave internal loopback");
		wr(`IEMG_OFF_MODE, 32'h3200_C84A);
		rdc(`IEMG_OFF_MODE, 32'h3200_C04A, "loopback while running");
		wr(`IEMG_OFF_MODE, 32'h3200_C048);
		idle(2);
		chk({30'h0, rx_state}, {30'h0, iemg_pkg::IEMG_STOPPED}, "rx stopped");
		rdc(`IEMG_OFF_STATUS, 32'h0000_8102, "rx stop flag");
	endtask

	// the filter verdict is reported whether or not everything is received
	task automatic t_rxall;
		for (int ra = 0; ra < 2; ra++) begin
			wr(`IEMG_OFF_MODE, ra ? 32'h7200_C048 : 32'h3200_C048);
			for (int mt = 0; mt < 2; mt++) begin
				@(posedge pclk);
				rx_filter_match <= mt[0];
				rx_frame_done   <= 1'h1;
				@(posedge pclk);
				rx_frame_done <= 1'h0;
				idle(1);
				chk({31'h0, rx_desc_match}, mt, "match verdict");
				chk({31'h0, rx_frame_accept}, mt | ra, "frame accept");
			end
		end
	endtask

	task automatic t_srst;
		// event held across the whole clear write: set must win
		status_event <= 14'h2000;
		wr(`IEMG_OFF_STAT_CLR, 32'hFFFF_FFFF);
		status_event <= 14'h0000;
		rdc(`IEMG_OFF_STATUS, 32'h0000_A000, "event beats clear");
		wr(`IEMG_OFF_MASK, 32'h0001_0001);
		pulse(0);
		irq_is(1'h1, "irq before soft reset");
		wr(`IEMG_OFF_BUS_MODE, 32'h0000_0001);
		irq_is(1'h0, "irq after soft reset");
		rdc(`IEMG_OFF_MASK, 32'hFFFE_0000, "mask after soft reset");
		rdc(`IEMG_OFF_MODE, 32'h3200_0040, "mode after soft reset");
		chk(operating_mode, 32'h3200_0040, "mode port after soft reset");
		rdc(`IEMG_OFF_TX_LIST, 32'h0000_1000, "tx base kept");
		wr(`IEMG_OFF_MODE, 32'h3200_2040);
		rdc(`IEMG_OFF_MODE, 32'h3200_0040, "base flag cleared");
	endtask

	// hardware reset in mid-run clears enables set by software
	task automatic t_hwrst;
		wr(`IEMG_OFF_MASK, 32'h0000_8008);
		pulse(3);
		irq_is(1'h1, "irq before hard reset");
		@(posedge pclk);
		presetn <= 1'h0;
		idle(2);
		presetn <= 1'h1;
		chk({31'h0, irq}, 32'h0, "irq after hard reset");
		rdc(`IEMG_OFF_MASK, 32'hFFFE_0000, "mask after hard reset");
		rdc(`IEMG_OFF_STATUS, 32'h0000_0000, "status after hard reset");
		chk(tx_list_base, 32'h0000_0000, "tx base after hard reset");
		irq_is(1'h0, "irq stays low after hard reset");
	endtask

	// hang guard; the whole run needs under a thousand cycles
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc >= 20000) begin
			chk(32'h0, 32'h1, "cycle limit reached");
			results();
		end
	end

	initial begin
		repeat (2) @(posedge pclk);
		presetn <= 1'h1;
		t_reset();
		t_gate();
		t_mode();
		t_rxall();
		t_srst();
		t_hwrst();
		results();
	end
endmodule
